/* File: rtl/charger_regs_defs.vh */
// Constants for the charger configuration register bank.
// Assumes inclusion by the bank module; definitions only.
`ifndef CHARGER_REGS_DEFS_VH
`define CHARGER_REGS_DEFS_VH

// Register addresses
`define ADDR_CHARGE_CONTROL   8'h01
`define ADDR_FLOAT_VOLTAGE    8'h02
`define ADDR_CHIP_ID          8'h03
`define ADDR_CHIP_ID_ALT      8'h3B
`define ADDR_CHARGE_CURRENT   8'h04

// Reset values
`define RST_CHARGE_CONTROL    8'h30
`define RST_FLOAT_VOLTAGE     8'h0A
`define RST_CHARGE_CURRENT    8'h89

// Field positions
`define CC_INPUT_CURRENT_LIMIT_HI           7
`define CC_INPUT_CURRENT_LIMIT_LO           6
`define CC_WEAK_HI            5
`define CC_WEAK_LO            4
`define CC_TERM_EN            3
`define CC_CHG_DIS            2
`define CC_HIZ                1
`define CC_BOOST              0
`define FV_VOLT_HI            7
`define FV_VOLT_LO            2
`define FV_PIN_POL            1
`define FV_PIN_EN             0
`define IB_PARAM_RST          7
`define IB_MAX_HI             6
`define IB_MAX_LO             4
`define IB_RSVD               3
`define IB_TERM_HI            2
`define IB_TERM_LO            0

// Serial bus framing
`define BITS_PER_BYTE         4'h8
`define DEV_ADDR_DEFAULT      7'h6A

`endif

/* File: rtl/charger_config_register_bank.v */
// Charger configuration and identification registers behind a serial two-wire slave.
// Assumes scl and sda inputs already synchronous to clk_sys and far slower than it.
//
// Function
// R1 - Charge control register resets to 30h; all its fields read and write.
// R2 - Charge control bits 7:6 select the input current limit.
// R3 - Charge control bits 5:4 select weak-battery threshold, 3.4 V to 3.7 V.
// R4 - Charge control bit 3 enables charge-current termination when one.
// R5 - Bit 2 one disables charger; bit 1 high-impedance; bit 0 boost mode.
// R6 - Output voltage register resets to 0Ah, float field 000010 meaning 3.54 V.
// R7 - Output voltage bits 7:2 set float voltage, 3.5 V plus 20 mV steps.
// R8 - Bit 1 sets boost-request pin polarity; bit 0 enables that pin.
// R9 - Identification register reads at two addresses, read-only, supplier code in 7:5.
// R10 - Identification bits 4:3 return a read-only part-number code.
// R11 - Identification bits 2:0 return the read-only minor revision.
// R12 - Charge current register resets to 89h.
// R13 - Writing one to charge current bit 7 restores charge parameters to defaults.
// R14 - Writing zero to that bit does nothing; it always reads one.
// R15 - Charge current bits 6:4 program the maximum charge current.
// R16 - Charge current bits 2:0 set the termination current.
// R17 - Host reads by sending address, repeated start, then device address with read.
`timescale 1ns/1ps
`default_nettype none
`include "charger_regs_defs.vh"

module charger_config_register_bank #(
	parameter [6:0] DEV_ADDR     = `DEV_ADDR_DEFAULT,
	parameter [2:0] VENDOR_CODE  = 3'h1,  // Arbitrary value
	parameter [1:0] PART_NUMBER  = 2'h0,  // Arbitrary value
	parameter [2:0] REVISION     = 3'h0   // Arbitrary value
) (
	input  wire       clk_sys,
	input  wire       nrst,
	input  wire       clkEn,
	input  wire       sclIn,
	input  wire       sdaIn,
	output wire       sdaOut,
	output wire       sdaOe,
	output wire [1:0] inputCurrentLimit,
	output wire [1:0] weakBatteryThreshold,
	output wire       terminationEnable,
	output wire       chargerDisable,
	output wire       highImpedanceSelect,
	output wire       boostSelect,
	output wire [5:0] floatVoltageField,
	output wire       boostPinPolarity,
	output wire       boostPinEnable,
	output wire [2:0] maxChargeCurrent,
	output wire [2:0] terminationCurrent
);

	localparam [8:0] S_IDLE    = 9'h001;
	localparam [8:0] S_DEVADDR = 9'h002;
	localparam [8:0] S_ACKA    = 9'h004;
	localparam [8:0] S_REGADDR = 9'h008;
	localparam [8:0] S_ACKR    = 9'h010;
	localparam [8:0] S_WDATA   = 9'h020;
	localparam [8:0] S_ACKW    = 9'h040;
	localparam [8:0] S_RDATA   = 9'h080;
	localparam [8:0] S_RACK    = 9'h100;

	reg [8:0] state_reg;
	reg [3:0] bitCnt_reg;
	reg [7:0] shift_reg;
	reg [7:0] ptr_reg;
	reg       readDir_reg;
	reg       hostNack_reg;
	reg       sdaOe_reg;
	reg       sdaOut_reg;
	reg       sclPrev_reg;
	reg       sdaPrev_reg;
	reg [7:0] chargeControl_reg;
	reg [7:0] floatVoltage_reg;
	reg [7:0] chargeCurrent_reg;
	reg [7:0] readData_next;
	reg [7:0] chargeControl_next;
	reg [7:0] floatVoltage_next;
	reg [7:0] chargeCurrent_next;

	wire startSeen;
	wire stopSeen;
	wire sclRise;
	wire sclFall;
	wire sclHigh;
	wire byteDone;
	wire writeStrobe;

	////////////////////////////////////////////////////////////////////////////////
	// Bus events

	// History regs freeze with clkEn, so a line change made during the freeze shows as an edge on resume
	assign sclHigh     = sclPrev_reg & sclIn;
	assign startSeen   = sclHigh & sdaPrev_reg & ~sdaIn;
	assign stopSeen    = sclHigh & ~sdaPrev_reg & sdaIn;
	assign sclRise     = ~sclPrev_reg & sclIn;
	assign sclFall     = sclPrev_reg & ~sclIn;
	assign byteDone    = (bitCnt_reg == `BITS_PER_BYTE);
	// A byte cut short by START or STOP never reaches the strobe
	assign writeStrobe = sclFall & (state_reg == S_WDATA) & byteDone;

	////////////////////////////////////////////////////////////////////////////////
	// Read multiplexer

	always @* begin
		case (ptr_reg)
			`ADDR_CHARGE_CONTROL: readData_next = chargeControl_reg;  // see R1
			`ADDR_FLOAT_VOLTAGE:  readData_next = floatVoltage_reg;
			`ADDR_CHIP_ID,
			`ADDR_CHIP_ID_ALT:    readData_next = {VENDOR_CODE, PART_NUMBER, REVISION};  // see R9 see R10 see R11
			`ADDR_CHARGE_CURRENT: begin
				// Reset bit and reserved bit always read as one
				readData_next = chargeCurrent_reg;
				readData_next[`IB_PARAM_RST] = 1'b1;  // see R14
				readData_next[`IB_RSVD] = 1'b1;
			end
			default:              readData_next = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register write decode

	always @* begin
		chargeControl_next = chargeControl_reg;
		floatVoltage_next  = floatVoltage_reg;
		chargeCurrent_next = chargeCurrent_reg;
		if (writeStrobe) begin
			case (ptr_reg)
				`ADDR_CHARGE_CONTROL: begin
					chargeControl_next = shift_reg;  // see R2 see R3 see R4 see R5
				end
				`ADDR_FLOAT_VOLTAGE: begin
					floatVoltage_next = shift_reg;  // see R7 see R8
				end
				`ADDR_CHARGE_CURRENT: begin
					if (shift_reg[`IB_PARAM_RST]) begin
						// Safety limits live elsewhere and are untouched
						chargeControl_next = `RST_CHARGE_CONTROL;  // see R13
						floatVoltage_next  = `RST_FLOAT_VOLTAGE;   // see R13
						chargeCurrent_next = `RST_CHARGE_CURRENT;  // see R13
					end else begin
						chargeCurrent_next = {1'h1,
							shift_reg[`IB_MAX_HI:`IB_MAX_LO], 1'h1,
							shift_reg[`IB_TERM_HI:`IB_TERM_LO]};  // see R14 see R15 see R16
					end
				end
				default: begin
					// Read-only and unmapped addresses ignore writes
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Slave engine

	always @(posedge clk_sys) begin
		if (!nrst) begin
			state_reg         <= S_IDLE;
			bitCnt_reg        <= 4'h0;
			shift_reg         <= 8'h00;
			ptr_reg           <= 8'h00;
			readDir_reg       <= 1'b0;
			hostNack_reg      <= 1'b0;
			sdaOe_reg         <= 1'b0;
			sdaOut_reg        <= 1'b0;
			sclPrev_reg       <= 1'b1;
			sdaPrev_reg       <= 1'b1;
		end else if (clkEn) begin
			sclPrev_reg <= sclIn;
			sdaPrev_reg <= sdaIn;
			sdaOut_reg  <= 1'b0;
			if (startSeen) begin
				// Repeated start keeps the pointer so a read follows the address write
				state_reg  <= S_DEVADDR;  // see R17
				bitCnt_reg <= 4'h0;
				sdaOe_reg  <= 1'b0;
			end else if (stopSeen) begin
				state_reg <= S_IDLE;
				sdaOe_reg <= 1'b0;
			end else if (sclRise) begin
				case (state_reg)
					S_DEVADDR, S_REGADDR, S_WDATA: begin
						shift_reg  <= {shift_reg[6:0], sdaIn};
						bitCnt_reg <= bitCnt_reg + 4'h1;
					end
					S_RDATA: begin
						shift_reg  <= {shift_reg[6:0], 1'b0};
						bitCnt_reg <= bitCnt_reg + 4'h1;
					end
					S_RACK: begin
						hostNack_reg <= sdaIn;
					end
					default: begin
					end
				endcase
			end else if (sclFall) begin
				case (state_reg)
					S_DEVADDR: begin
						if (bitCnt_reg == `BITS_PER_BYTE) begin
							if (shift_reg[7:1] == DEV_ADDR) begin
								readDir_reg <= shift_reg[0];
								sdaOe_reg   <= 1'b1;
								state_reg   <= S_ACKA;
							end else begin
								state_reg <= S_IDLE;
							end
						end
					end
					S_ACKA: begin
						bitCnt_reg <= 4'h0;
						if (readDir_reg) begin
							shift_reg <= readData_next;
							sdaOe_reg <= ~readData_next[7];
							state_reg <= S_RDATA;
						end else begin
							sdaOe_reg <= 1'b0;
							state_reg <= S_REGADDR;
						end
					end
					S_REGADDR: begin
						if (bitCnt_reg == `BITS_PER_BYTE) begin
							ptr_reg   <= shift_reg;
							sdaOe_reg <= 1'b1;
							state_reg <= S_ACKR;
						end
					end
					S_ACKR, S_ACKW: begin
						sdaOe_reg  <= 1'b0;
						bitCnt_reg <= 4'h0;
						state_reg  <= S_WDATA;
					end
					S_WDATA: begin
						if (bitCnt_reg == `BITS_PER_BYTE) begin
							sdaOe_reg <= 1'b1;
							state_reg <= S_ACKW;
						end
					end
					S_RDATA: begin
						if (bitCnt_reg == `BITS_PER_BYTE) begin
							sdaOe_reg <= 1'b0;
							state_reg <= S_RACK;
						end else begin
							sdaOe_reg <= ~shift_reg[7];
						end
					end
					S_RACK: begin
						bitCnt_reg <= 4'h0;
						if (hostNack_reg) begin
							sdaOe_reg <= 1'b0;
							state_reg <= S_IDLE;
						end else begin
							// No auto-increment: repeated reads return the same register
							shift_reg <= readData_next;
							sdaOe_reg <= ~readData_next[7];
							state_reg <= S_RDATA;
						end
					end
					default: begin
						sdaOe_reg <= 1'b0;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register file

	// Whole bytes kept once, so read mux and field outputs share one copy
	// Parameter reset and nrst load the same defaults
	always @(posedge clk_sys) begin
		if (!nrst) begin
			chargeControl_reg <= `RST_CHARGE_CONTROL;  // see R1
			floatVoltage_reg  <= `RST_FLOAT_VOLTAGE;   // see R6
			chargeCurrent_reg <= `RST_CHARGE_CURRENT;  // see R12
		end else if (clkEn) begin
			chargeControl_reg <= chargeControl_next;
			floatVoltage_reg  <= floatVoltage_next;
			chargeCurrent_reg <= chargeCurrent_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign sdaOut               = sdaOut_reg;
	assign sdaOe                = sdaOe_reg;
	assign inputCurrentLimit    = chargeControl_reg[`CC_INPUT_CURRENT_LIMIT_HI:`CC_INPUT_CURRENT_LIMIT_LO];  // see R2
	assign weakBatteryThreshold = chargeControl_reg[`CC_WEAK_HI:`CC_WEAK_LO];    // see R3
	assign terminationEnable    = chargeControl_reg[`CC_TERM_EN];                // see R4
	assign chargerDisable       = chargeControl_reg[`CC_CHG_DIS];                // see R5
	assign highImpedanceSelect  = chargeControl_reg[`CC_HIZ];                    // see R5
	assign boostSelect          = chargeControl_reg[`CC_BOOST];                  // see R5
	assign floatVoltageField    = floatVoltage_reg[`FV_VOLT_HI:`FV_VOLT_LO];     // see R7
	assign boostPinPolarity     = floatVoltage_reg[`FV_PIN_POL];                 // see R8
	assign boostPinEnable       = floatVoltage_reg[`FV_PIN_EN];                  // see R8
	assign maxChargeCurrent     = chargeCurrent_reg[`IB_MAX_HI:`IB_MAX_LO];      // see R15
	assign terminationCurrent   = chargeCurrent_reg[`IB_TERM_HI:`IB_TERM_LO];    // see R16

endmodule // charger_config_register_bank
`default_nettype wire

/* File: bench/charger_regs_chk.sv */
// Port checker for the charger register bank.
// Assumes the bank's ports only; bound after the module.
`timescale 1ns/1ps
`default_nettype none
module charger_regs_chk (
	input wire logic       clk_sys,
	input wire logic       nrst,
	input wire logic       clkEn,
	input wire logic       sclIn,
	input wire logic       sdaIn,
	input wire logic       sdaOut,
	input wire logic       sdaOe,
	input wire logic [1:0] inputCurrentLimit,
	input wire logic [1:0] weakBatteryThreshold,
	input wire logic       terminationEnable,
	input wire logic       chargerDisable,
	input wire logic       highImpedanceSelect,
	input wire logic       boostSelect,
	input wire logic [5:0] floatVoltageField,
	input wire logic       boostPinPolarity,
	input wire logic       boostPinEnable,
	input wire logic [2:0] maxChargeCurrent,
	input wire logic [2:0] terminationCurrent
);
	wire [21:0] flds = {inputCurrentLimit, weakBatteryThreshold, terminationEnable,
		chargerDisable, highImpedanceSelect, boostSelect, floatVoltageField,
		boostPinPolarity, boostPinEnable, maxChargeCurrent, terminationCurrent};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	//////////////////////////////////////////////////
	pin_low_a: assert property (sdaOut == 1'b0)
		else $error("sda output not low");
	rst_ctl_a: assert property ($rose(nrst) && $past(clkEn) |-> flds[21:6] == 16'h300A)
		else $error("control or float reset value wrong");
	rst_cur_a: assert property ($rose(nrst) && $past(clkEn) |-> flds[5:0] == 6'h01)
		else $error("current reset value wrong");
	freeze_a: assert property (!clkEn |=> $stable({flds, sdaOe}))
		else $error("state moved while clock enable low");
	upd_at_ack_a: assert property ($changed(flds) |-> $rose(sdaOe))
		else $error("fields changed outside data ack");
	drive_rise_a: assert property ($rose(sdaOe) |-> !$past(sclIn))
		else $error("sda pull began without scl low");
	drive_fall_a: assert property ($fell(sdaOe) |-> !$past(sclIn))
		else $error("sda pull ended without scl low");
	scl_high_a: assert property (sclIn && $past(sclIn) && $past(clkEn) |-> $stable(sdaOe))
		else $error("sda moved while scl high");
	cover property ($rose(sdaOe));
	cover property ($changed(flds));
	cover property (!clkEn);
endmodule // charger_regs_chk
bind charger_config_register_bank charger_regs_chk chk (.clk_sys, .nrst, .clkEn, .sclIn,
	.sdaIn, .sdaOut, .sdaOe, .inputCurrentLimit, .weakBatteryThreshold, .terminationEnable,
	.chargerDisable, .highImpedanceSelect, .boostSelect, .floatVoltageField,
	.boostPinPolarity, .boostPinEnable, .maxChargeCurrent, .terminationCurrent);
`default_nettype wire

/* File: bench/i2c_host_model.sv */
// Two-wire host that programs the charger registers.
// Assumes callers start tasks just after a falling clk edge.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
	input  wire logic clk_sys,
	input  wire logic sdaOe,
	output var logic  sclIn,
	output wire logic sdaIn
);
	logic sdaDrv = 1'b1;
	initial sclIn = 1'b1;
	// Pull-up: a released line reads high, never a stale value
	assign sdaIn = sdaDrv & ~sdaOe;
	// Half period of 4 cycles keeps above the 3-cycle minimum
	task hc;
		repeat (4) @(negedge clk_sys);
	endtask
	task start;
		sdaDrv = 1'b1;
		hc;
		sclIn = 1'b1;
		hc;
		sdaDrv = 1'b0;
		hc;
		sclIn = 1'b0;
	endtask
	task stop;
		sdaDrv = 1'b0;
		hc;
		sclIn = 1'b1;
		hc;
		sdaDrv = 1'b1;
		hc;
	endtask
	task bitx(input logic b, output logic r);
		sdaDrv = b;
		hc;
		sclIn = 1'b1;
		hc;
		r = sdaIn;
		sclIn = 1'b0;
	endtask
	task xfer(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--)
			bitx(b[i], r[i]);
	endtask
endmodule // i2c_host_model
`default_nettype wire

/* File: bench/tb_charger_config_register_bank.sv */
// Self-checking bench for the charger register bank.
// Assumes the host model drives the serial pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
	$display("wrong value t=%0t got %h exp %h", $time, a, e); n_mismatch++; end end
module tb_charger_config_register_bank;
	// Identity values are arbitrary
	localparam logic [7:0] ID = {3'h5, 2'h2, 3'h3};
	logic       clk_sys = 1'b0;
	logic       nrst = 1'b0;
	logic       clkEn = 1'b1;
	wire        sdaOut, sdaOe, sclIn, sdaIn;
	wire [21:0] f;
	logic [7:0] cc = 8'h30, fv = 8'h0A, ib = 8'h89;
	logic [7:0] adr [6] = '{8'h01, 8'h02, 8'h03, 8'h3B, 8'h04, 8'h07};
	int         n_mismatch = 0, num_checks = 0;
	always #20 clk_sys = ~clk_sys;
	charger_config_register_bank #(.VENDOR_CODE(3'h5), .PART_NUMBER(2'h2), .REVISION(3'h3))
	dut (.clk_sys, .nrst, .clkEn, .sclIn, .sdaIn, .sdaOut, .sdaOe,
		.inputCurrentLimit(f[21:20]), .weakBatteryThreshold(f[19:18]),
		.terminationEnable(f[17]), .chargerDisable(f[16]), .highImpedanceSelect(f[15]),
		.boostSelect(f[14]), .floatVoltageField(f[13:8]), .boostPinPolarity(f[7]),
		.boostPinEnable(f[6]), .maxChargeCurrent(f[5:3]), .terminationCurrent(f[2:0]));
	i2c_host_model h (.clk_sys, .sdaOe, .sclIn, .sdaIn);
	//////////////////////////////////////////////////
	function automatic logic [7:0] exp(input logic [7:0] a);
		case (a)
			8'h01: return cc;
			8'h02: return fv;
			8'h03, 8'h3B: return ID;
			8'h04: return ib;
			default: return 8'h00;
		endcase
	endfunction
	task wb(input logic [7:0] b);
		logic [7:0] r;
		logic k;
		h.xfer(b, r);
		h.bitx(1'b1, k);
		`CHK(k, 1'b0)
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] d2;
		logic k;
		h.start;
		wb(8'hD4);
		wb(a);
		h.start;
		wb(8'hD5);
		h.xfer(8'hFF, d);
		h.bitx(1'b0, k);
		h.xfer(8'hFF, d2);
		h.bitx(1'b1, k);
		h.stop;
		`CHK(d2, d)
	endtask
	task wr(input logic [7:0] a, d);
		h.start;
		wb(8'hD4);
		wb(a);
		wb(d);
		h.stop;
		if (a == 8'h01) cc = d;
		if (a == 8'h02) fv = d;
		if (a == 8'h04) ib = d | 8'h88;
		if (a == 8'h04 && d[7]) begin
			cc = 8'h30;
			fv = 8'h0A;
			ib = 8'h89;
		end
	endtask
	task chkAll;
		logic [7:0] d;
		foreach (adr[i]) begin
			rd(adr[i], d);
			`CHK(d, exp(adr[i]))
		end
		`CHK(f, {cc, fv, ib[6:4], ib[2:0]})
	endtask
	task results;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (80000) @(posedge clk_sys);
		n_mismatch++;
		results;
	end
	initial begin
		logic [7:0] a, d;
		logic [21:0] p;
		logic k;
		void'($urandom(32'h2fa2));
		repeat (8) @(negedge clk_sys);
		nrst = 1'b1;
		repeat (2) @(negedge clk_sys);
		chkAll;
		$display("test 1 done");
		repeat (6) begin
			a = 8'h01 << ($urandom % 3);
			d = 8'($urandom);
			if (a == 8'h04) d[7] = 1'b0;
			wr(a, d);
			chkAll;
		end
		$display("test 2 done");
		wr(8'h03, 8'($urandom));
		wr(8'h3B, 8'($urandom));
		wr(8'h07, 8'($urandom));
		chkAll;
		$display("test 3 done");
		wr(8'h04, 8'h80 | 8'($urandom));
		chkAll;
		$display("test 4 done");
		// Back-to-back data bytes land in the same register; a cut byte is dropped
		h.start;
		wb(8'hD4);
		wb(8'h01);
		wb(8'hC3);
		wb(8'h5A);
		repeat (4) h.bitx(1'h0, k);
		h.stop;
		cc = 8'h5A;
		chkAll;
		$display("test 5 done");
		h.start;
		h.xfer(8'hD6, d);
		h.bitx(1'b1, k);
		h.stop;
		`CHK(k, 1'b1)
		// A frozen bank neither acks nor stores a whole write
		p = f;
		clkEn = 1'h0;
		h.start;
		h.xfer(8'hD4, d);
		h.bitx(1'h1, k);
		`CHK(k, 1'h1)
		h.xfer(8'h01, d);
		h.bitx(1'h1, k);
		h.xfer(~cc, d);
		h.bitx(1'h1, k);
		h.stop;
		clkEn = 1'h1;
		`CHK(f, p)
		$display("test 6 done");
		// Reset in mid-run restores every default
		nrst = 1'h0;
		repeat (2) @(negedge clk_sys);
		nrst = 1'h1;
		cc = 8'h30;
		fv = 8'h0A;
		ib = 8'h89;
		chkAll;
		$display("test 7 done");
		results;
	end
endmodule // tb_charger_config_register_bank
`default_nettype wire
